// ==== bench/serial_iface_checker_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module serial_iface_checker (
	input wire logic mclk_in, // clock
	input wire logic arst_n_in, // reset
	input wire logic [2:0] addr_in, // index
	input wire logic [7:0] wdata_in, // write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	input wire logic [7:0] rdata_out, // read data
	input wire logic rxd_in, // rx line
	input wire logic txd_out, // tx line
	input wire logic sck_in, // pin level
	input wire logic sck_out, // pin drive
	input wire logic sck_oe_out, // pin enable
	input wire logic tx_empty_irq_out, // empty request
	input wire logic tx_done_irq_out, // end request
	input wire logic rx_full_irq_out, // full request
	input wire logic rx_error_irq_out // error request
);
	logic [7:0] fmt_sh;
	logic [7:0] ctl_sh;
	logic [7:0] baud_sh;
	logic oe_want;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!arst_n_in);

	////////////////////////////////////////
	// shadow copies of written settings
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fmt_sh <= 8'h00;
			ctl_sh <= 8'h00;
			baud_sh <= 8'h1f;
		end else if (wr_in) begin
			if (addr_in == 3'h0) fmt_sh <= wdata_in;
			if (addr_in == 3'h1) ctl_sh <= wdata_in;
			if (addr_in == 3'h5) baud_sh <= wdata_in;
		end
	end
	// pin driven only in async mode, code 01
	assign oe_want = (ctl_sh[1:0] == 2'h1) && !fmt_sh[7];

	////////////////////////////////////////
	// properties on the top ports
	a_disable_sets_empty: assert property (
		wr_in && addr_in == 3'h1 && !wdata_in[5] ##2 rd_in && addr_in == 3'h2 |=> rdata_out[7])
		else $error("empty flag not forced when transmitter off");
	a_clock_pin_drive: assert property (oe_want == $past(oe_want) |-> sck_oe_out == oe_want)
		else $error("clock pin enable does not follow clock code");
	a_done_irq_gate: assert property (tx_done_irq_out |-> ctl_sh[2])
		else $error("end request without its enable");
	a_full_irq_gate: assert property (rx_full_irq_out |-> ctl_sh[6])
		else $error("full request without its enable");
	a_error_irq_gate: assert property (rx_error_irq_out |-> ctl_sh[6])
		else $error("error request without its enable");
	a_empty_irq_gate: assert property (tx_empty_irq_out |-> ctl_sh[7] && ctl_sh[5])
		else $error("empty request without its enables");
	a_tx_off_mark: assert property (!ctl_sh[5] && !$past(ctl_sh[5]) |-> txd_out)
		else $error("line not at mark with transmitter off");
	a_reserved_mark: assert property (ctl_sh[1:0] == 2'h3 && $past(txd_out) |-> txd_out)
		else $error("line moved under reserved clock code");
	a_format_readback: assert property (
		rd_in && addr_in == 3'h0 |=> rdata_out == (fmt_sh & 8'hfc))
		else $error("format read back differs");
	a_sck_half_bit: assert property (
		sck_oe_out && baud_sh == 8'h01 && $rose(sck_out) |-> ##15 sck_out ##1 !sck_out)
		else $error("clock output high phase not half a bit");
endmodule

bind serial_iface_unit serial_iface_checker u_checker (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.rxd_in(rxd_in), .txd_out(txd_out), .sck_in(sck_in), .sck_out(sck_out),
	.sck_oe_out(sck_oe_out), .tx_empty_irq_out(tx_empty_irq_out),
	.tx_done_irq_out(tx_done_irq_out), .rx_full_irq_out(rx_full_irq_out),
	.rx_error_irq_out(rx_error_irq_out));

`default_nettype wire

// ==== bench/serial_peer.sv ====
`timescale 1ns/1ps
`default_nettype none

module serial_peer (
	input wire logic clk_in, // system clock
	input wire logic line_in, // line from the unit
	output var logic line_out // line into the unit
);
	// line rests at mark from time zero
	initial line_out = 1'b1;

	// one frame, bit length in clocks, stops given separately
	task automatic send(input int bitc, input logic [7:0] d, input int n, input logic eon,
		input logic eb, input logic s1, input logic s2, input int ns);
		logic q[$];
		q = {1'b0};
		for (int i = 0; i < n; i++) q.push_back(d[i]);
		if (eon) q.push_back(eb);
		q.push_back(s1);
		if (ns == 2) q.push_back(s2);
		@(posedge clk_in);
		foreach (q[i]) begin
			line_out <= q[i];
			repeat (bitc) @(posedge clk_in);
		end
		line_out <= 1'b1;
	endtask

	// capture one frame at mid bit, count clocks waited for the start
	task automatic get(input int bitc, input int n, input logic eon, input int ns,
		output logic [7:0] d, output logic eb, output logic ok, output int wc);
		wc = 0;
		d = 8'h00;
		eb = 1'b0;
		while (line_in !== 1'b0) begin
			@(negedge clk_in);
			wc++;
		end
		repeat (bitc / 2) @(negedge clk_in);
		ok = ~line_in;
		for (int i = 0; i < n; i++) begin
			repeat (bitc) @(negedge clk_in);
			d[i] = line_in;
		end
		if (eon) begin
			repeat (bitc) @(negedge clk_in);
			eb = line_in;
		end
		for (int i = 0; i < ns; i++) begin
			repeat (bitc) @(negedge clk_in);
			ok = ok & line_in;
		end
	endtask
endmodule

`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic mclk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [2:0] addr_in = 3'h0;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic sck_in = 1'b0;
	logic rxd_in;
	logic [7:0] rdata_out;
	logic txd_out, sck_out, sck_oe_out, ti, tdi, ri, ei, m, pb, ps;
	logic [7:0] f, tx, rx, d, pd, d2, mask;
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;
	int k, wc;
	logic [7:0] row_fmt [12] = '{8'h00, 8'h08, 8'h20, 8'h38, 8'h40, 8'h48, 8'h70, 8'h68,
		8'h24, 8'h2c, 8'h44, 8'h4c};
	logic [7:0] rst_val [8] = '{8'h00, 8'h00, 8'h84, 8'hff, 8'h00, 8'h1f, 8'h00, 8'h00};

	serial_iface_unit u_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.rxd_in(rxd_in), .txd_out(txd_out), .sck_in(sck_in), .sck_out(sck_out),
		.sck_oe_out(sck_oe_out), .tx_empty_irq_out(ti), .tx_done_irq_out(tdi),
		.rx_full_irq_out(ri), .rx_error_irq_out(ei));
	serial_peer u_peer (.clk_in(mclk_in), .line_in(txd_out), .line_out(rxd_in));

	////////////////////////////////////////
	// system clock, and a free 16x clock of eight system clocks
	initial begin
		forever #5 mclk_in = ~mclk_in;
	end
	initial begin
		forever #40 sck_in = ~sck_in;
	end
	// hang guard
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			final_report();
		end
	end

	////////////////////////////////////////
	// helpers
	task automatic final_report();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		@(negedge mclk_in);
		v = rdata_out;
	endtask
	task automatic wait_done();
		for (int i = 0; i < 80 && tdi !== 1'b1; i++) @(posedge mclk_in);
	endtask
	// parity or multiprocessor bit for a character
	function automatic logic ext_bit(input logic [7:0] g, input logic [7:0] v, input logic b);
		if (g[2]) return b;
		return (g[6] ? ^v[6:0] : ^v) ^ g[4];
	endfunction

	////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		for (int i = 0; i < 8; i++) begin
			reg_rd(i[2:0], d);
			chk(d, rst_val[i]);
		end
		chk(txd_out, 1'b1);
		reg_wr(3'h5, 8'h01);
		// every format, both directions at once
		for (int i = 0; i < 12; i++) begin
			f = row_fmt[i];
			m = i[0];
			tx = 8'h5a + 8'(i * 37);
			rx = 8'hc3 + 8'(i * 11);
			mask = f[6] ? 8'h7f : 8'hff;
			reg_wr(3'h1, 8'h00);
			reg_wr(3'h0, f);
			reg_wr(3'h1, 8'hf4);
			reg_wr(3'h3, tx);
			reg_wr(3'h2, {7'h3d, m});
			fork
				u_peer.send(32, rx, f[6] ? 7 : 8, f[5] | f[2], ext_bit(f, rx, ~m), 1'b1, 1'b1,
					f[3] ? 2 : 1);
				u_peer.get(32, f[6] ? 7 : 8, f[5] | f[2], f[3] ? 2 : 1, pd, pb, ps, wc);
			join
			chk(pd, tx & mask);
			chk(pb, (f[5] | f[2]) & ext_bit(f, tx, m));
			chk(ps, 1'b1);
			wait_done();
			reg_rd(3'h4, d);
			chk(d, rx & mask);
			reg_rd(3'h2, d);
			chk(d & {6'h3f, f[2], 1'b1}, {6'h31, f[2] & ~m, m});
			chk({ti, tdi, ri, ei}, 8'h0e);
			reg_wr(3'h2, 8'hbe | m);
		end
		// chained frames
		reg_wr(3'h1, 8'h00);
		reg_wr(3'h0, 8'h00);
		reg_wr(3'h1, 8'hf4);
		fork
			begin
				u_peer.get(32, 8, 1'b0, 1, pd, pb, ps, wc);
				u_peer.get(32, 8, 1'b0, 1, d2, pb, ps, wc);
			end
			begin
				reg_wr(3'h3, 8'h81);
				reg_wr(3'h2, 8'h7a);
				for (k = 0; k < 40; k++) begin
					reg_rd(3'h2, d);
					if (d[7] === 1'b1) break;
				end
				reg_wr(3'h3, 8'h7e);
				reg_wr(3'h2, 8'h7e);
			end
		join
		chk(d[7], 1'b1);
		chk(pd, 8'h81);
		chk(d2, 8'h7e);
		chk(wc <= 17, 1'b1);
		wait_done();
		chk(tdi, 1'b1);
		chk(txd_out, 1'b1);
		// clock output phase
		reg_wr(3'h1, 8'h00);
		reg_wr(3'h1, 8'h31);
		reg_wr(3'h3, 8'hc9);
		reg_wr(3'h2, 8'h7e);
		fork
			u_peer.get(32, 8, 1'b0, 1, pd, pb, ps, wc);
			begin
				wait (txd_out === 1'b0);
				for (k = 0; k < 40 && sck_out !== 1'b1; k++) @(negedge mclk_in);
			end
		join
		chk(k >= 15 && k <= 17, 1'b1);
		chk(sck_oe_out, 1'b1);
		chk(pd, 8'hc9);
		reg_wr(3'h1, 8'h00);
		reg_wr(3'h1, 8'h74);
		// overrun, then hold off until flags are cleared
		u_peer.send(32, 8'h11, 8, 1'b0, 1'b0, 1'b1, 1'b1, 1);
		u_peer.send(32, 8'h22, 8, 1'b0, 1'b0, 1'b1, 1'b1, 1);
		reg_rd(3'h4, d);
		chk(d, 8'h11);
		reg_rd(3'h2, d);
		chk(d & 8'h78, 8'h60);
		chk(ei, 1'b1);
		u_peer.send(32, 8'h33, 8, 1'b0, 1'b0, 1'b1, 1'b1, 1);
		reg_rd(3'h4, d);
		chk(d, 8'h11);
		reg_wr(3'h2, 8'h86);
		u_peer.send(32, 8'h44, 8, 1'b0, 1'b0, 1'b1, 1'b1, 1);
		reg_rd(3'h4, d);
		chk(d, 8'h44);
		reg_wr(3'h2, 8'h86);
		// wrong odd parity bit
		reg_wr(3'h1, 8'h00);
		reg_wr(3'h0, 8'h30);
		reg_wr(3'h1, 8'h74);
		u_peer.send(32, 8'h07, 8, 1'b1, 1'b1, 1'b1, 1'b1, 1);
		reg_rd(3'h2, d);
		chk(d & 8'h78, 8'h08);
		reg_rd(3'h4, d);
		chk(d, 8'h44);
		reg_wr(3'h2, 8'h86);
		// first of two stops low
		reg_wr(3'h1, 8'h00);
		reg_wr(3'h0, 8'h08);
		reg_wr(3'h1, 8'h74);
		u_peer.send(32, 8'h5c, 8, 1'b0, 1'b0, 1'b0, 1'b1, 2);
		reg_rd(3'h4, d);
		chk(d, 8'h5c);
		// switch off: empty forced, receive state kept
		reg_wr(3'h1, 8'h00);
		reg_rd(3'h2, d);
		chk(d & 8'hf8, 8'h90);
		reg_wr(3'h2, 8'h7e);
		reg_rd(3'h2, d);
		chk(d & 8'hf8, 8'h90);
		reg_rd(3'h4, d);
		chk(d, 8'h5c);
		reg_wr(3'h2, 8'h86);
		// external 16x clock
		reg_wr(3'h0, 8'h00);
		reg_wr(3'h1, 8'h32);
		reg_wr(3'h3, 8'h69);
		fork
			u_peer.send(128, 8'h96, 8, 1'b0, 1'b0, 1'b1, 1'b1, 1);
			u_peer.get(128, 8, 1'b0, 1, pd, pb, ps, wc);
			reg_wr(3'h2, 8'h7e);
		join
		chk(pd, 8'h69);
		reg_rd(3'h4, d);
		chk(d, 8'h96);
		chk(sck_oe_out, 1'b0);
		// reserved clock code: nothing runs
		reg_wr(3'h1, 8'h00);
		reg_wr(3'h1, 8'h33);
		reg_wr(3'h3, 8'h55);
		reg_wr(3'h2, 8'h7e);
		repeat (100) @(posedge mclk_in);
		reg_rd(3'h2, d);
		chk(d[7], 1'b0);
		chk(txd_out, 1'b1);
		reg_wr(3'h1, 8'h00);
		final_report();
	end
endmodule

`default_nettype wire

// ==== core/baud_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

module baud_tick_gen #(
	parameter int DIV_W = 8 // divisor width
) (
	input wire logic mclk_in, // system clock
	input wire logic rst_n_in, // synchronous copy of reset
	input wire logic run_in, // legal clock setting
	input wire logic use_ext_in, // take ticks from the pin
	input wire logic ext_edge_in, // filtered rising edge of pin
	input wire logic [DIV_W-1:0] div_in, // internal divisor
	output logic tick_out // one 16x tick, one cycle
);

	logic [DIV_W-1:0] cnt;

	// divider reloads on zero, tick every div_in+1 clocks
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= '0;
			tick_out <= 1'b0;
		end else begin
			if (!run_in || use_ext_in || cnt == '0) begin
				cnt <= div_in;
			end else begin
				cnt <= cnt - 1'b1;
			end
			tick_out <= run_in & (use_ext_in ? ext_edge_in : (cnt == '0));
		end
	end

endmodule
`default_nettype wire

// ==== core/serial_iface_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_iface_defines.svh"
// What this block does
// - line idles high, falling edge starts
// - start, data lsb first, parity, stops
// - sample each bit on eighth 16x tick
// - twelve formats from length, parity, stops, mp
// - clock source from mode and clock bits
// - codes: internal, internal+output, external, reserved
// - clock output rises mid bit
// - transmit disable forces empty flag high
// - receive disable keeps flags and data
// - empty flag low: load shifter, set flag
// - during stop bit, pending data chains frame
// - nothing pending: set done, stay mark
// - receive shifts lsb first, then parity, stops
// - parity checked against odd or even
// - only first stop bit checked for one
// - clean character: store, set full, request
// - error sets its flag, full unchanged
// - overrun or parity error blocks store
// - receiver waits while error flags set
// - independent double-buffered transmit and receive
// - done flag means no data supplied

module serial_iface_unit (
	input wire logic mclk_in, // system clock, 100 MHz
	input wire logic arst_n_in, // asynchronous reset
	input wire logic [2:0] addr_in, // register index
	input wire logic [7:0] wdata_in, // write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	output logic [7:0] rdata_out, // read data, cycle after rd_in
	input wire logic rxd_in, // serial receive line
	output logic txd_out, // serial transmit line
	input wire logic sck_in, // serial clock pin level
	output logic sck_out, // serial clock pin drive value
	output logic sck_oe_out, // serial clock pin driven
	output logic tx_empty_irq_out, // transmit empty request
	output logic tx_done_irq_out, // transmit end request
	output logic rx_full_irq_out, // receive full request
	output logic rx_error_irq_out // receive error request
);
	import serial_iface_pkg::*;

	////////////////////////////////////////////////////////////////
	// reset release

	logic [1:0] rst_pipe;
	logic rst_n;

	// assert at once, release after two clocks
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe[1];

	////////////////////////////////////////////////////////////////
	// pin synchronisers and glitch filter

	logic [2:0] rxd_sync;
	logic [2:0] sck_sync;
	logic rxd_lvl;
	logic rxd_lvl_d;
	logic sck_lvl;
	logic sck_lvl_d;
	logic rx_fell;
	logic sck_rise;

	// a level change counts once stages two and three agree
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			rxd_sync <= 3'h7;
			sck_sync <= 3'h7;
			rxd_lvl <= 1'b1;
			rxd_lvl_d <= 1'b1;
			sck_lvl <= 1'b1;
			sck_lvl_d <= 1'b1;
		end else begin
			rxd_sync <= {rxd_sync[1:0], rxd_in};
			sck_sync <= {sck_sync[1:0], sck_in};
			if (rxd_sync[1] == rxd_sync[2]) begin
				rxd_lvl <= rxd_sync[1];
			end
			if (sck_sync[1] == sck_sync[2]) begin
				sck_lvl <= sck_sync[1];
			end
			rxd_lvl_d <= rxd_lvl;
			sck_lvl_d <= sck_lvl;
		end
	end

	// edges of the filtered levels
	assign rx_fell = rxd_lvl_d & ~rxd_lvl;
	assign sck_rise = sck_lvl & ~sck_lvl_d;

	////////////////////////////////////////////////////////////////
	// registers

	logic [7:0] serial_format_reg;
	logic [7:0] serial_control_reg;
	logic [7:0] tx_holding_reg;
	logic [7:0] rx_holding_reg;
	logic [7:0] baud_div_reg;
	logic tx_empty_flag;
	logic tx_done_flag;
	logic rx_full_flag;
	logic overrun_flag;
	logic framing_flag;
	logic parity_flag;
	logic multiproc_bit;
	logic mpb_tx;
	logic [7:0] serial_flag_reg;
	logic [7:0] rd_mux;

	// write decode
	logic wr_format;
	logic wr_control;
	logic wr_flags;
	logic wr_tx_hold;
	logic wr_baud;

	assign wr_format = wr_in & (addr_in == `REG_FORMAT);
	assign wr_control = wr_in & (addr_in == `REG_CONTROL);
	assign wr_flags = wr_in & (addr_in == `REG_FLAGS);
	assign wr_tx_hold = wr_in & (addr_in == `REG_TX_HOLD);
	assign wr_baud = wr_in & (addr_in == `REG_BAUD);

	// control and format fields
	fmt_t fmt;
	logic tx_enable_bit;
	logic rx_enable_bit;
	logic tx_irq_enable;
	logic rx_irq_enable;
	logic tx_done_irq_enable;
	logic clk_src_sel_hi;
	logic clk_src_sel_lo;
	logic [1:0] clk_code;

	assign fmt = fmt_t'(serial_format_reg[7:2]);
	assign tx_enable_bit = serial_control_reg[`CTL_TE];
	assign rx_enable_bit = serial_control_reg[`CTL_RE];
	assign tx_irq_enable = serial_control_reg[`CTL_TIE];
	assign rx_irq_enable = serial_control_reg[`CTL_RIE];
	assign tx_done_irq_enable = serial_control_reg[`CTL_TX_DONE_IRQ_ENABLE];
	assign clk_src_sel_hi = serial_control_reg[`CTL_CLK_SRC_SEL_HI];
	assign clk_src_sel_lo = serial_control_reg[`CTL_CLK_SRC_SEL_LO];
	assign clk_code = {clk_src_sel_hi, clk_src_sel_lo};

	// flag clears: a written 0 clears, a written 1 leaves alone
	logic clr_tx_empty_flag;
	logic clr_tx_done_flag;
	logic clr_rx_full_flag;
	logic clr_oer;
	logic clr_fer;
	logic clr_per;

	assign clr_tx_empty_flag = wr_flags & ~wdata_in[`FLG_TX_EMPTY_FLAG];
	assign clr_tx_done_flag = wr_flags & ~wdata_in[`FLG_TX_DONE_FLAG];
	assign clr_rx_full_flag = wr_flags & ~wdata_in[`FLG_RX_FULL_FLAG];
	assign clr_oer = wr_flags & ~wdata_in[`FLG_OER];
	assign clr_fer = wr_flags & ~wdata_in[`FLG_FER];
	assign clr_per = wr_flags & ~wdata_in[`FLG_PER];

	// software-owned configuration and transmit data
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			serial_format_reg <= `FORMAT_RST;
			serial_control_reg <= `CONTROL_RST;
			tx_holding_reg <= `TX_HOLD_RST;
			baud_div_reg <= `BAUD_RST;
			mpb_tx <= 1'b0;
		end else begin
			if (wr_format) serial_format_reg <= wdata_in & `FORMAT_MASK;
			if (wr_control) serial_control_reg <= wdata_in & `CONTROL_MASK;
			if (wr_tx_hold) tx_holding_reg <= wdata_in;
			if (wr_baud) baud_div_reg <= wdata_in;
			if (wr_flags) mpb_tx <= wdata_in[`FLG_MPB_TX];
		end
	end

	////////////////////////////////////////////////////////////////
	// clock source selection

	logic run_ok;
	logic use_ext;
	logic tick;

	// only asynchronous mode with a non-reserved code runs
	assign run_ok = ~fmt.com & (clk_code != 2'h3);
	assign use_ext = (clk_code == `CKE_EXT);

	baud_tick_gen #(
		.DIV_W(8)
	) u_tick (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n),
		.run_in(run_ok),
		.use_ext_in(use_ext),
		.ext_edge_in(sck_rise),
		.div_in(baud_div_reg),
		.tick_out(tick)
	);

	////////////////////////////////////////////////////////////////
	// transmitter

	logic tx_take;
	logic tx_done;
	logic [3:0] tx_phase;

	serial_tx_engine u_tx (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n),
		.tick_in(tick),
		.enable_in(tx_enable_bit & run_ok),
		.fmt_in(fmt),
		.mpb_in(mpb_tx),
		.pending_in(~tx_empty_flag),
		.data_in(tx_holding_reg),
		.take_out(tx_take),
		.done_out(tx_done),
		.txd_out(txd_out),
		.phase_out(tx_phase)
	);

	// bit-rate clock out, low first half, rising at bit centre
	assign sck_oe_out = run_ok & (clk_code == `CKE_INT_OUT);
	assign sck_out = tx_phase[3];

	////////////////////////////////////////////////////////////////
	// receiver

	rx_state_t rx_state;
	logic [3:0] rx_tick_cnt;
	logic [3:0] rx_idx;
	logic [7:0] rx_shifter;
	logic rx_extra;
	logic rx_live;
	logic rx_go;
	logic rx_sample;
	logic [3:0] rx_dlen;
	logic [3:0] rx_stop_idx;
	logic rx_in_data;
	logic rx_in_extra;
	logic rx_fin;
	logic rx_false_start;
	logic [7:0] rx_word;
	logic par_bad;
	logic frm_bad;
	logic ovr_bad;
	logic rx_store;
	logic rx_good;

	// receive enable and restart gate
	assign rx_live = rx_enable_bit & run_ok;
	assign rx_go = rx_live & ~(overrun_flag | framing_flag | parity_flag);

	// sample point and bit position decode
	assign rx_sample = (rx_state == RX_RUN) & tick & (rx_tick_cnt == `SAMPLE_TICK);
	assign rx_dlen = data_len(fmt);
	assign rx_stop_idx = rx_dlen + {3'h0, has_extra(fmt)} + 4'h1;
	assign rx_in_data = (rx_idx != 4'h0) & (rx_idx <= rx_dlen);
	assign rx_in_extra = has_extra(fmt) & (rx_idx == rx_dlen + 4'h1);
	assign rx_fin = rx_sample & (rx_idx == rx_stop_idx);
	assign rx_false_start = rx_sample & (rx_idx == 4'h0) & rxd_lvl;

	// character checks at the first stop bit
	assign rx_word = fmt.char7 ? {1'b0, rx_shifter[7:1]} : rx_shifter;
	assign par_bad = fmt.par_en & ~fmt.mp
		& ((data_ones(rx_word, fmt.char7) ^ rx_extra) != fmt.par_odd);
	assign frm_bad = ~rxd_lvl;
	assign ovr_bad = rx_full_flag;
	assign rx_store = rx_fin & ~ovr_bad & ~par_bad;
	assign rx_good = rx_store & ~frm_bad;

	// frame walk: restart count at the edge, sixteen ticks a bit
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= RX_IDLE;
			rx_tick_cnt <= 4'h0;
			rx_idx <= 4'h0;
			rx_shifter <= 8'h00;
			rx_extra <= 1'b0;
		end else begin
			case (rx_state)
				RX_IDLE: begin
					if (rx_go && rx_fell) begin
						rx_state <= RX_RUN;
						rx_tick_cnt <= 4'h0;
						rx_idx <= 4'h0;
					end
				end
				RX_RUN: begin
					if (!rx_live || rx_false_start || rx_fin) begin
						rx_state <= RX_IDLE;
					end else if (tick) begin
						rx_tick_cnt <= rx_tick_cnt + 4'h1;
						if (rx_sample) begin
							rx_idx <= rx_idx + 4'h1;
							if (rx_in_data) rx_shifter <= {rxd_lvl, rx_shifter[7:1]};
							if (rx_in_extra) rx_extra <= rxd_lvl;
						end
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// receive holding register and received multiprocessor bit
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			rx_holding_reg <= `RX_HOLD_RST;
			multiproc_bit <= 1'b0;
		end else if (rx_store) begin
			rx_holding_reg <= rx_word;
			multiproc_bit <= fmt.mp & rx_extra;
		end
	end

	////////////////////////////////////////////////////////////////
	// status flags, a hardware set wins over a software clear

	// transmit side flags
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_empty_flag <= 1'b1;
			tx_done_flag <= 1'b1;
		end else begin
			if (!tx_enable_bit || tx_take) tx_empty_flag <= 1'b1;
			else if (clr_tx_empty_flag) tx_empty_flag <= 1'b0;
			if (tx_done) tx_done_flag <= 1'b1;
			else if (clr_tx_done_flag) tx_done_flag <= 1'b0;
		end
	end

	// receive side flags, untouched by the receive enable
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			rx_full_flag <= 1'b0;
			overrun_flag <= 1'b0;
			framing_flag <= 1'b0;
			parity_flag <= 1'b0;
		end else begin
			if (rx_good) rx_full_flag <= 1'b1;
			else if (clr_rx_full_flag) rx_full_flag <= 1'b0;
			if (rx_fin && ovr_bad) overrun_flag <= 1'b1;
			else if (clr_oer) overrun_flag <= 1'b0;
			if (rx_fin && frm_bad) framing_flag <= 1'b1;
			else if (clr_fer) framing_flag <= 1'b0;
			if (rx_fin && par_bad) parity_flag <= 1'b1;
			else if (clr_per) parity_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// requests and read port

	// level requests gated by their enables
	assign tx_empty_irq_out = tx_irq_enable & tx_enable_bit & tx_empty_flag;
	assign tx_done_irq_out = tx_done_irq_enable & tx_done_flag;
	assign rx_full_irq_out = rx_irq_enable & rx_full_flag;
	assign rx_error_irq_out = rx_irq_enable
		& (overrun_flag | framing_flag | parity_flag);

	// read selection, unmapped index reads zero
	assign serial_flag_reg = {tx_empty_flag, rx_full_flag, overrun_flag, framing_flag,
		parity_flag, tx_done_flag, multiproc_bit, mpb_tx};
	assign rd_mux = (addr_in == `REG_FORMAT) ? serial_format_reg
		: (addr_in == `REG_CONTROL) ? serial_control_reg
		: (addr_in == `REG_FLAGS) ? serial_flag_reg
		: (addr_in == `REG_TX_HOLD) ? tx_holding_reg
		: (addr_in == `REG_RX_HOLD) ? rx_holding_reg
		: (addr_in == `REG_BAUD) ? baud_div_reg
		: 8'h00;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_out <= 8'h00;
		end else begin
			rdata_out <= rd_in ? rd_mux : 8'h00;
		end
	end

endmodule
`default_nettype wire

// ==== core/serial_tx_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_iface_defines.svh"

module serial_tx_engine (
	input wire logic mclk_in, // system clock
	input wire logic rst_n_in, // synchronous copy of reset
	input wire logic tick_in, // 16x tick
	input wire logic enable_in, // transmitter enabled
	input wire serial_iface_pkg::fmt_t fmt_in, // frame format
	input wire logic mpb_in, // multiprocessor bit to send
	input wire logic pending_in, // holding register full
	input wire logic [7:0] data_in, // holding register
	output logic take_out, // holding moved to shifter
	output logic done_out, // frame ended, nothing pending
	output logic txd_out, // serial line
	output logic [3:0] phase_out // tick phase within bit
);
	import serial_iface_pkg::*;

	tx_state_t state;
	logic [3:0] ph;
	logic [3:0] left;
	logic [11:0] sh;
	logic [11:0] frame;
	logic [3:0] dlen;
	logic [3:0] xidx;
	logic [3:0] frame_len;
	logic xbit;
	logic bit_end;
	logic last_bit;
	logic start_ok;

	// bit timing and hand-off decisions
	assign dlen = data_len(fmt_in);
	assign xidx = dlen + 4'h1;
	assign frame_len = 4'h1 + dlen + {3'h0, has_extra(fmt_in)} + (fmt_in.two_stop ? 4'h2 : 4'h1);
	assign xbit = fmt_in.mp ? mpb_in : (data_ones(data_in, fmt_in.char7) ^ fmt_in.par_odd);
	assign bit_end = tick_in & (ph == `TICK_LAST);
	assign last_bit = (state == TX_SEND) & (left == 4'h1);
	assign start_ok = enable_in & pending_in & ((state == TX_IDLE) | last_bit);
	assign take_out = bit_end & start_ok;
	assign done_out = bit_end & last_bit & ~start_ok;
	assign txd_out = sh[0];
	assign phase_out = ph;

	// start low, data lsb first, parity or mp bit, stops high
	always_comb begin
		frame = 12'hFFF;
		frame[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < dlen) begin
				frame[i + 1] = data_in[i];
			end
		end
		if (has_extra(fmt_in)) begin
			frame[xidx] = xbit;
		end
	end

	// shifter idles all ones so the line rests at mark
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= TX_IDLE;
			ph <= 4'h0;
			left <= 4'h0;
			sh <= 12'hFFF;
		end else begin
			if (tick_in) begin
				ph <= ph + 4'h1;
			end
			if (!enable_in || done_out) begin
				state <= TX_IDLE;
				left <= 4'h0;
				sh <= 12'hFFF;
			end else if (take_out) begin
				state <= TX_SEND;
				left <= frame_len;
				sh <= frame;
			end else if (bit_end && state == TX_SEND) begin
				left <= left - 4'h1;
				sh <= {1'b1, sh[11:1]};
			end
		end
	end

endmodule
`default_nettype wire

// ==== shared/serial_iface_defines.svh ====
`ifndef SERIAL_IFACE_DEFINES_SVH
`define SERIAL_IFACE_DEFINES_SVH

// register indices on the plain register port
`define REG_FORMAT 3'h0
`define REG_CONTROL 3'h1
`define REG_FLAGS 3'h2
`define REG_TX_HOLD 3'h3
`define REG_RX_HOLD 3'h4
`define REG_BAUD 3'h5

// control register bit positions
`define CTL_TIE 7
`define CTL_RIE 6
`define CTL_TE 5
`define CTL_RE 4
`define CTL_TX_DONE_IRQ_ENABLE 2
`define CTL_CLK_SRC_SEL_HI 1
`define CTL_CLK_SRC_SEL_LO 0

// flag register bit positions
`define FLG_TX_EMPTY_FLAG 7
`define FLG_RX_FULL_FLAG 6
`define FLG_OER 5
`define FLG_FER 4
`define FLG_PER 3
`define FLG_TX_DONE_FLAG 2
`define FLG_MPB_RX 1
`define FLG_MPB_TX 0

// reset values and writable masks
`define FORMAT_RST 8'h00
`define FORMAT_MASK 8'hFC
`define CONTROL_RST 8'h00
`define CONTROL_MASK 8'hF7
`define TX_HOLD_RST 8'hFF
`define RX_HOLD_RST 8'h00
`define BAUD_RST 8'h1F

// clock source codes in asynchronous mode
`define CKE_INT 2'h0
`define CKE_INT_OUT 2'h1
`define CKE_EXT 2'h2

// sixteen ticks per bit, sample on the eighth
`define TICK_LAST 4'hF
`define SAMPLE_TICK 4'h7

`endif

// ==== shared/serial_iface_pkg.sv ====
package serial_iface_pkg;

	// frame format fields, same order as format register bits 7..2
	typedef struct packed {
		logic com;
		logic char7;
		logic par_en;
		logic par_odd;
		logic two_stop;
		logic mp;
	} fmt_t;

	typedef enum logic {RX_IDLE, RX_RUN} rx_state_t;
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

	// number of data bits in a character
	function automatic logic [3:0] data_len(input fmt_t f);
		return f.char7 ? 4'h7 : 4'h8;
	endfunction

	// parity or multiprocessor bit present
	function automatic logic has_extra(input fmt_t f);
		return f.mp | f.par_en;
	endfunction

	// xor of the data bits in use
	function automatic logic data_ones(input logic [7:0] d, input logic c7);
		return c7 ? ^d[6:0] : ^d;
	endfunction

endpackage
